//--- src/pmi_cfg.svh
// Offsets, field positions, reset values and timing counts of the link.
`ifndef PMI_CFG_SVH
`define PMI_CFG_SVH

// Device registers, reached through the device's own register port.
`define PMI_CTL_OFFSET      16'h0032
`define PMI_DCTL_OFFSET     16'h0086
`define PMI_CTL_RESET       16'h0080
`define PMI_DCTL_RESET      16'h0000
`define PMI_CTL_EN_BIT      7
`define PMI_CTL_TXSHIFT_BIT 1
`define PMI_CTL_RXSHIFT_BIT 0
`define PMI_DCTL_TX_LSB     4
`define PMI_DCTL_RX_LSB     0

// Half periods of the link clocks, in ref_clk cycles, per speed.
`define PMI_HALF_10         40
`define PMI_HALF_100        4
`define PMI_HALF_1000       2

// Controller registers on AHB-Lite.
`define PMI_MAC_CTRL_OFF    32'h0000_0000
`define PMI_MAC_TXD_OFF     32'h0000_0004
`define PMI_MAC_STAT_OFF    32'h0000_0008
`define PMI_MAC_RUN_BIT     0
`define PMI_MAC_SPD_LSB     1
`define PMI_MAC_TXERR_BIT   8

`endif

//--- src/pmi_pkg.sv
// Types shared by both ends of the parallel MAC link.
package pmi_pkg;

    // Link speed; the order gives the two-bit code used in registers.
    typedef enum logic [1:0] {
        PMI_SPD_10,
        PMI_SPD_100,
        PMI_SPD_1000
    } pmi_speed_type;

endpackage // pmi_pkg

//--- src/pmi_if.sv
// Link wires between the device end and the MAC end.
`timescale 1ns/1ps
interface pmi_if;
    logic       txClk;
    logic [3:0] txData;
    logic       txCtl;
    logic       rxClk;
    logic [3:0] rxData;
    logic       rxCtl;

    // The device drives the receive group, the MAC the transmit group.
    modport device (input txClk, txData, txCtl, output rxClk, rxData, rxCtl);
    modport mac (output txClk, txData, txCtl, input rxClk, rxData, rxCtl);
endinterface // pmi_if

//--- src/pmi_device.sv
// Device end of the parallel MAC link: receive launcher and transmit capture.
`timescale 1ns/1ps
`include "pmi_cfg.svh"
module pmi_device
    import pmi_pkg::*;
#(
    parameter int HALF_10   = `PMI_HALF_10,
    parameter int HALF_100  = `PMI_HALF_100,
    parameter int HALF_1000 = `PMI_HALF_1000
) (
    // Clock and reset.
    input  wire logic          ref_clk,
    input  wire logic          rst_n,
    // Link pins.
    pmi_if.device              link,
    // Register port.
    input  wire logic [15:0]   regAddr,
    input  wire logic          regWrite,
    input  wire logic [15:0]   regWdata,
    output wire logic [15:0]   regRdata,
    // Straps and mode pins.
    input  wire logic [2:0]    strapTxDelay,
    input  wire logic [2:0]    strapRxDelay,
    input  wire logic          serialEnable,
    input  wire pmi_speed_type linkSpeed,
    // Received bytes to be sent towards the MAC.
    input  wire logic [7:0]    rxByte,
    input  wire logic          rxValid,
    input  wire logic          rxErrIn,
    output wire logic          rxTake,
    // Bytes captured from the MAC.
    output wire logic [7:0]    txByte,
    output wire logic          txStrobe,
    output wire logic          txErr,
    output wire logic          txFrame,
    // Status.
    output wire logic          parallelActive,
    output wire logic [3:0]    txSkew,
    output wire logic [3:0]    rxSkew
);

    // Refuse half periods that the counter cannot hold or that leave no
    // room for the two-flop sampling at the far end.
    if (HALF_10 < 2 || HALF_10 > 255 || HALF_100 < 2 || HALF_100 > 255 ||
        HALF_1000 < 2 || HALF_1000 > 255) begin : g_bad_half
        $error("pmi_device: half periods must lie in 2..255");
    end

    logic [6:0]  pinSync1_q;
    logic [6:0]  pinSync2_q;
    logic        strapTaken_q;
    logic [2:0]  strapTx_q;
    logic [2:0]  strapRx_q;
    logic [15:0] ctl_q;
    logic [15:0] dctl_q;
    logic        dlyFromReg_q;
    logic [15:0] regRdata_q;
    logic        active_q;
    logic [3:0]  txSkew_q;
    logic [3:0]  rxSkew_q;
    logic [7:0]  halfLen;
    logic [7:0]  cnt_q;
    logic        rxClk_q;
    logic        fallNow;
    logic        riseNow;
    logic [3:0]  rxData_q;
    logic        rxCtl_q;
    logic [7:0]  curByte_q;
    logic        curEn_q;
    logic        curErr_q;
    logic        take_q;
    logic [5:0]  linkSync1_q;
    logic [5:0]  linkSync2_q;
    logic [5:0]  linkSync3_q;
    logic        txRise;
    logic        txFall;
    logic [3:0]  loNib_q;
    logic        enBit_q;
    logic [7:0]  txByte_q;
    logic        txStrobe_q;
    logic        txErr_q;
    logic        txFrame_q;

    // Straps and the serial enable are pins, so they pass two flops first.
    // The flops run through reset so that the straps are settled in them
    // by the time reset is released.
    always_ff @(posedge ref_clk) begin
        pinSync1_q <= {serialEnable, strapTxDelay, strapRxDelay};
        pinSync2_q <= pinSync1_q;
    end

    // Straps are caught once, after the synchroniser has filled.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            strapTaken_q <= 1'b0;
            strapTx_q    <= 3'h0;
            strapRx_q    <= 3'h0;
        end else if (!strapTaken_q) begin
            strapTaken_q <= 1'b1;
            strapTx_q    <= pinSync2_q[5:3];
            strapRx_q    <= pinSync2_q[2:0];
        end
    end

    // Register writes; the strap skew applies until software writes
    // the delay register.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctl_q        <= `PMI_CTL_RESET;
            dctl_q       <= `PMI_DCTL_RESET;
            dlyFromReg_q <= 1'b0;
        end else if (regWrite) begin
            if (regAddr == `PMI_CTL_OFFSET) begin
                ctl_q <= regWdata;
            end
            if (regAddr == `PMI_DCTL_OFFSET) begin
                dctl_q       <= regWdata;
                dlyFromReg_q <= 1'b1;
            end
        end
    end

    // Register read data appears one cycle after the address.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            regRdata_q <= 16'h0000;
        end else if (regAddr == `PMI_CTL_OFFSET) begin
            regRdata_q <= ctl_q;
        end else if (regAddr == `PMI_DCTL_OFFSET) begin
            regRdata_q <= dctl_q;
        end else begin
            regRdata_q <= 16'h0000;
        end
    end

    // The serial interface wins over the parallel enable.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            active_q <= 1'b0;
        end else begin
            active_q <= ctl_q[`PMI_CTL_EN_BIT] & ~pinSync2_q[6];
        end
    end

    // Skew in quarter-nanosecond units. The delay line itself is analog,
    // so this block only reports the setting it would apply. A strap step
    // is two quarter steps.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            txSkew_q <= 4'h0;
            rxSkew_q <= 4'h0;
        end else begin
            if (!ctl_q[`PMI_CTL_TXSHIFT_BIT]) begin
                txSkew_q <= 4'h0;
            end else if (dlyFromReg_q) begin
                txSkew_q <= dctl_q[`PMI_DCTL_TX_LSB +: 4];
            end else begin
                txSkew_q <= {strapTx_q, 1'b0};
            end
            if (!ctl_q[`PMI_CTL_RXSHIFT_BIT]) begin
                rxSkew_q <= 4'h0;
            end else if (dlyFromReg_q) begin
                rxSkew_q <= dctl_q[`PMI_DCTL_RX_LSB +: 4];
            end else begin
                rxSkew_q <= {strapRx_q, 1'b0};
            end
        end
    end

    // Half period per speed. Real rates are 125, 25 and 2.5 MHz; at this
    // reference only their ratio between 10 and 100 is kept.
    always_comb begin
        unique case (linkSpeed)
            PMI_SPD_10:   halfLen = 8'(HALF_10);
            PMI_SPD_100:  halfLen = 8'(HALF_100);
            PMI_SPD_1000: halfLen = 8'(HALF_1000);
            default:      halfLen = 8'(HALF_10);
        endcase
    end

    assign fallNow = (cnt_q == 8'h00) && rxClk_q;
    assign riseNow = (cnt_q == 8'h00) && !rxClk_q && active_q;

    // Receive clock divider. A new speed is only picked up at the end of
    // a phase, so a change stretches or shortens whole phases and never
    // cuts one short into a glitch.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt_q   <= 8'h00;
            rxClk_q <= 1'b0;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end else begin
            cnt_q <= halfLen - 8'h01;
            if (rxClk_q) begin
                rxClk_q <= 1'b0;
            end else if (active_q) begin
                rxClk_q <= 1'b1;
            end
        end
    end

    // Launcher: data changes on the opposite edge to the one that samples
    // it, giving the far end half a period of setup.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rxData_q  <= 4'h0;
            rxCtl_q   <= 1'b0;
            curByte_q <= 8'h00;
            curEn_q   <= 1'b0;
            curErr_q  <= 1'b0;
            take_q    <= 1'b0;
        end else begin
            take_q <= 1'b0;
            if (fallNow) begin
                if (rxValid && active_q) begin
                    curByte_q <= rxByte;
                    curEn_q   <= 1'b1;
                    curErr_q  <= rxErrIn;
                    take_q    <= 1'b1;
                    rxData_q  <= rxByte[3:0];
                    rxCtl_q   <= 1'b1;
                end else begin
                    curEn_q  <= 1'b0;
                    curErr_q <= 1'b0;
                    rxData_q <= 4'h0;
                    rxCtl_q  <= 1'b0;
                end
            end else if (riseNow) begin
                rxData_q <= curByte_q[7:4];
                rxCtl_q  <= curEn_q ^ curErr_q;
            end
        end
    end

    // Transmit pins pass two flops; the third stage keeps the values that
    // stood just before a detected clock edge.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            linkSync1_q <= 6'h00;
            linkSync2_q <= 6'h00;
            linkSync3_q <= 6'h00;
        end else begin
            linkSync1_q <= {link.txClk, link.txCtl, link.txData};
            linkSync2_q <= linkSync1_q;
            linkSync3_q <= linkSync2_q;
        end
    end

    assign txRise = linkSync2_q[5] && !linkSync3_q[5];
    assign txFall = !linkSync2_q[5] && linkSync3_q[5];

    // Capture: low nibble and enable at the rising edge, high nibble and
    // coded error at the falling edge.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            loNib_q    <= 4'h0;
            enBit_q    <= 1'b0;
            txByte_q   <= 8'h00;
            txStrobe_q <= 1'b0;
            txErr_q    <= 1'b0;
            txFrame_q  <= 1'b0;
        end else begin
            txStrobe_q <= 1'b0;
            txErr_q    <= 1'b0;
            if (txRise && active_q) begin
                loNib_q <= linkSync3_q[3:0];
                enBit_q <= linkSync3_q[4];
            end else if (txFall && active_q) begin
                txByte_q   <= {linkSync3_q[3:0], loNib_q};
                txStrobe_q <= enBit_q;
                txErr_q    <= enBit_q ^ linkSync3_q[4];
                txFrame_q  <= enBit_q;
            end else if (!active_q) begin
                txFrame_q <= 1'b0;
            end
        end
    end

    assign link.rxClk     = rxClk_q;
    assign link.rxData    = rxData_q;
    assign link.rxCtl     = rxCtl_q;
    assign regRdata       = regRdata_q;
    assign rxTake         = take_q;
    assign txByte         = txByte_q;
    assign txStrobe       = txStrobe_q;
    assign txErr          = txErr_q;
    assign txFrame        = txFrame_q;
    assign parallelActive = active_q;
    assign txSkew         = txSkew_q;
    assign rxSkew         = rxSkew_q;

endmodule // pmi_device

//--- src/pmi_mac.sv
// MAC end of the parallel link with an AHB-Lite register slave.
`timescale 1ns/1ps
`include "pmi_cfg.svh"
module pmi_mac
    import pmi_pkg::*;
#(
    parameter int HALF_10   = `PMI_HALF_10,
    parameter int HALF_100  = `PMI_HALF_100,
    parameter int HALF_1000 = `PMI_HALF_1000
) (
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // Link pins.
    pmi_if.mac               link,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output wire logic [31:0] hrdata,
    output wire logic        hreadyout,
    output wire logic        hresp
);

    // Same limits as the device end.
    if (HALF_10 < 2 || HALF_10 > 255 || HALF_100 < 2 || HALF_100 > 255 ||
        HALF_1000 < 2 || HALF_1000 > 255) begin : g_bad_half
        $error("pmi_mac: half periods must lie in 2..255");
    end

    logic          accept;
    logic          wrPend_q;
    logic [31:0]   wrAddr_q;
    logic [31:0]   hrdata_q;
    logic [2:0]    ctrl_q;
    pmi_speed_type speed;
    logic [8:0]    txReg_q;
    logic          txPend_q;
    logic          txTake;
    logic [7:0]    rxByte_q;
    logic          rxValid_q;
    logic          rxErr_q;
    logic          rxFrame_q;
    logic          rdClr;
    logic [7:0]    halfLen;
    logic [7:0]    cnt_q;
    logic          txClk_q;
    logic          fallNow;
    logic          riseNow;
    logic [3:0]    txData_q;
    logic          txCtl_q;
    logic [7:0]    curByte_q;
    logic          curEn_q;
    logic          curErr_q;
    logic [5:0]    sync1_q;
    logic [5:0]    sync2_q;
    logic [5:0]    sync3_q;
    logic          rxRise;
    logic          rxFall;
    logic [3:0]    loNib_q;
    logic          enBit_q;
    logic          ready_q;
    logic          hresp_q;

    // Ready and response come from flops; the slave never waits and
    // always answers OKAY.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ready_q <= 1'b1;
            hresp_q <= 1'b0;
        end else begin
            ready_q <= 1'b1;
            hresp_q <= 1'b0;
        end
    end

    // Only whole-word single transfers are expected; hsize is not decoded.
    assign accept = hsel && htrans[1] && hready;
    assign rdClr  = accept && !hwrite && (haddr == `PMI_MAC_STAT_OFF);
    assign speed  = pmi_speed_type'(ctrl_q[`PMI_MAC_SPD_LSB +: 2]);
    assign txTake = fallNow && txPend_q && ctrl_q[`PMI_MAC_RUN_BIT];

    // Address phase is latched; read data is ready for the data phase, so
    // the slave never inserts wait states.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wrPend_q <= 1'b0;
            wrAddr_q <= 32'h0000_0000;
            hrdata_q <= 32'h0000_0000;
        end else begin
            wrPend_q <= accept && hwrite;
            if (accept) begin
                wrAddr_q <= haddr;
            end
            if (accept && !hwrite) begin
                unique case (haddr)
                    `PMI_MAC_CTRL_OFF: hrdata_q <= {29'h0, ctrl_q};
                    `PMI_MAC_TXD_OFF:  hrdata_q <= {23'h0, txReg_q};
                    `PMI_MAC_STAT_OFF: hrdata_q <= {16'h0, rxByte_q, 4'h0,
                        rxFrame_q, rxErr_q, rxValid_q, txPend_q};
                    default:           hrdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Control register; speed and run are set by software once it knows
    // the device speed.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_q <= 3'h0;
        end else if (wrPend_q && wrAddr_q == `PMI_MAC_CTRL_OFF) begin
            ctrl_q <= hwdata[2:0];
        end
    end

    // One-byte transmit holding register. A write while full is dropped unless
    // the held byte is taken in that cycle; the pending flag tells software when it may write again.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            txReg_q  <= 9'h000;
            txPend_q <= 1'b0;
        end else if (wrPend_q && wrAddr_q == `PMI_MAC_TXD_OFF &&
                     (!txPend_q || txTake)) begin
            txReg_q  <= hwdata[8:0];
            txPend_q <= 1'b1;
        end else if (txTake) begin
            txPend_q <= 1'b0;
        end
    end

    always_comb begin
        unique case (speed)
            PMI_SPD_10:   halfLen = 8'(HALF_10);
            PMI_SPD_100:  halfLen = 8'(HALF_100);
            PMI_SPD_1000: halfLen = 8'(HALF_1000);
            default:      halfLen = 8'(HALF_10);
        endcase
    end

    assign fallNow = (cnt_q == 8'h00) && txClk_q;
    assign riseNow = (cnt_q == 8'h00) && !txClk_q &&
                     ctrl_q[`PMI_MAC_RUN_BIT];

    // Transmit clock divider: it stays low while run is clear, and a high
    // phase always completes, so stopping cannot leave a runt pulse.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt_q   <= 8'h00;
            txClk_q <= 1'b0;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end else begin
            cnt_q <= halfLen - 8'h01;
            if (txClk_q) begin
                txClk_q <= 1'b0;
            end else if (ctrl_q[`PMI_MAC_RUN_BIT]) begin
                txClk_q <= 1'b1;
            end
        end
    end

    // Launcher, mirror of the device's receive launcher.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            txData_q  <= 4'h0;
            txCtl_q   <= 1'b0;
            curByte_q <= 8'h00;
            curEn_q   <= 1'b0;
            curErr_q  <= 1'b0;
        end else if (fallNow) begin
            curEn_q   <= txTake;
            curErr_q  <= txTake && txReg_q[`PMI_MAC_TXERR_BIT];
            curByte_q <= txReg_q[7:0];
            txData_q  <= txTake ? txReg_q[3:0] : 4'h0;
            txCtl_q   <= txTake;
        end else if (riseNow) begin
            txData_q <= curByte_q[7:4];
            txCtl_q  <= curEn_q ^ curErr_q;
        end
    end

    // Receive pins pass two flops, a third keeps pre-edge values.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sync1_q <= 6'h00;
            sync2_q <= 6'h00;
            sync3_q <= 6'h00;
        end else begin
            sync1_q <= {link.rxClk, link.rxCtl, link.rxData};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    assign rxRise = sync2_q[5] && !sync3_q[5];
    assign rxFall = !sync2_q[5] && sync3_q[5];

    // Received byte and sticky flags; a new byte beats a status read.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            loNib_q   <= 4'h0;
            enBit_q   <= 1'b0;
            rxByte_q  <= 8'h00;
            rxValid_q <= 1'b0;
            rxErr_q   <= 1'b0;
            rxFrame_q <= 1'b0;
        end else if (rxRise) begin
            loNib_q <= sync3_q[3:0];
            enBit_q <= sync3_q[4];
            if (rdClr) begin
                rxValid_q <= 1'b0;
                rxErr_q   <= 1'b0;
            end
        end else if (rxFall) begin
            rxFrame_q <= enBit_q;
            if (enBit_q) begin
                rxByte_q  <= {sync3_q[3:0], loNib_q};
                rxValid_q <= 1'b1;
            end else if (rdClr) begin
                rxValid_q <= 1'b0;
            end
            rxErr_q <= (enBit_q ^ sync3_q[4]) || (rxErr_q && !rdClr);
        end else if (rdClr) begin
            rxValid_q <= 1'b0;
            rxErr_q   <= 1'b0;
        end
    end

    assign link.txClk  = txClk_q;
    assign link.txData = txData_q;
    assign link.txCtl  = txCtl_q;
    assign hrdata      = hrdata_q;
    assign hreadyout   = ready_q;
    assign hresp       = hresp_q;

endmodule // pmi_mac

//--- src/pmi_mac_end_note.sv
// Spare source slot of the MAC end; it holds no logic.

//--- tb/pmi_asserts.sv
// Link checker: clock phases, launch edges and the edge at which control may rise.
`timescale 1ns/1ps
module pmi_asserts (
    // Clock and reset.
    input wire logic       ref_clk,
    input wire logic       rst_n,
    // Link wires.
    input wire logic       txClk,
    input wire logic [3:0] txData,
    input wire logic       txCtl,
    input wire logic       rxClk,
    input wire logic [3:0] rxData,
    input wire logic       rxCtl
);
    // The bench runs at 100 Mbps, so each clock phase lasts four cycles.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_high(c); c [*4]; endsequence
    sequence s_low(c); !c [*4]; endsequence
    property p_rx_high; $rose(rxClk) |-> s_high(rxClk); endproperty
    property p_rx_low; $fell(rxClk) |-> s_low(rxClk); endproperty
    property p_tx_high; $rose(txClk) |-> s_high(txClk); endproperty
    property p_tx_low; $fell(txClk) |-> s_low(txClk); endproperty
    property p_rx_launch;
        $changed(rxData) || $changed(rxCtl) |-> $changed(rxClk);
    endproperty
    property p_tx_launch;
        $changed(txData) || $changed(txCtl) |-> $changed(txClk);
    endproperty
    property p_rx_start; $rose(rxCtl) |-> $fell(rxClk); endproperty
    property p_tx_start; $rose(txCtl) |-> $fell(txClk); endproperty
    a_rx_high: assert property (p_rx_high)
        else $error("receive clock high phase too short");
    a_rx_low: assert property (p_rx_low)
        else $error("receive clock low phase too short");
    a_tx_high: assert property (p_tx_high)
        else $error("transmit clock high phase too short");
    a_tx_low: assert property (p_tx_low)
        else $error("transmit clock low phase too short");
    a_rx_launch: assert property (p_rx_launch)
        else $error("receive wires moved off a clock edge");
    a_tx_launch: assert property (p_tx_launch)
        else $error("transmit wires moved off a clock edge");
    a_rx_start: assert property (p_rx_start)
        else $error("receive control rose at a rising clock");
    a_tx_start: assert property (p_tx_start)
        else $error("transmit control rose at a rising clock");
endmodule // pmi_asserts

//--- tb/rgmii_mac_side_interface_test.sv
// Bench joining both link ends, driven through their register ports.
`timescale 1ns/1ps
module rgmii_mac_side_interface_test;
    import pmi_pkg::*;
    logic ref_clk = 0, rst_n = 0, hwrite = 0, regWrite = 0, serialEnable = 0;
    logic rxValid = 0, rxErrIn = 0, hready;
    logic [1:0] htrans = 0;
    logic [7:0] rxByte = 0;
    logic [15:0] regAddr = 0, regWdata = 0;
    logic [31:0] haddr = 0, hwdata = 0, rd;
    wire logic [15:0] regRdata;
    wire logic [7:0] txByte;
    wire logic [3:0] txSkew, rxSkew;
    wire logic [31:0] hrdata;
    wire logic rxTake, txStrobe, txErr, txFrame, parallelActive, hresp;
    int miscompares = 0, compares = 0;
    pmi_if link ();
    pmi_device i_pmi_device (.ref_clk(ref_clk), .rst_n(rst_n), .link(link),
        .regAddr(regAddr), .regWrite(regWrite), .regWdata(regWdata),
        .regRdata(regRdata), .strapTxDelay(3'h3), .strapRxDelay(3'h1),
        .serialEnable(serialEnable), .linkSpeed(PMI_SPD_100),
        .rxByte(rxByte), .rxValid(rxValid), .rxErrIn(rxErrIn),
        .rxTake(rxTake), .txByte(txByte), .txStrobe(txStrobe), .txErr(txErr),
        .txFrame(txFrame), .parallelActive(parallelActive),
        .txSkew(txSkew), .rxSkew(rxSkew));
    pmi_mac i_pmi_mac (.ref_clk(ref_clk), .rst_n(rst_n), .link(link),
        .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp));
    pmi_asserts i_pmi_asserts (.ref_clk(ref_clk), .rst_n(rst_n),
        .txClk(link.txClk), .txData(link.txData), .txCtl(link.txCtl),
        .rxClk(link.rxClk), .rxData(link.rxData), .rxCtl(link.rxCtl));
    // Clock of 100 ns.
    initial forever #50 ref_clk = ~ref_clk;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One single AHB transfer; the master waits on hready in both phases.
    task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
        @(posedge ref_clk) htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge ref_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge ref_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    // Device register access; read data stands one cycle after the address.
    task dreg(input logic w, input logic [15:0] a, input logic [15:0] wd);
        @(posedge ref_clk) regAddr <= a;
        regWrite <= w;
        regWdata <= wd;
        @(posedge ref_clk) regWrite <= 1'b0;
        @(posedge ref_clk) #1 rd = {16'h0, regRdata};
    endtask
    task give_verdict;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Watchdog; the whole sequence needs well under 20000 cycles.
    initial begin
        #2000000 miscompares++;
        give_verdict();
    end
    initial begin
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        dreg(0, `PMI_CTL_OFFSET, 0); chk(rd, 32'h0080);
        dreg(0, `PMI_DCTL_OFFSET, 0); chk(rd, 32'h0000);
        chk({txSkew, rxSkew}, 8'h00);
        dreg(1, `PMI_CTL_OFFSET, 16'h0083);
        chk({txSkew, rxSkew}, 8'h62);
        dreg(1, `PMI_DCTL_OFFSET, 16'h0095);
        dreg(0, `PMI_DCTL_OFFSET, 0); chk(rd, 32'h0095);
        chk({txSkew, rxSkew}, 8'h95);
        dreg(0, 16'h0033, 0); chk(rd, 32'h0);
        serialEnable <= 1'b1;
        dreg(0, `PMI_CTL_OFFSET, 0); chk(parallelActive, 1'b0);
        serialEnable <= 1'b0;
        dreg(1, `PMI_CTL_OFFSET, 16'h0000); chk(parallelActive, 1'b0);
        dreg(1, `PMI_CTL_OFFSET, 16'h0080); chk(parallelActive, 1'b1);
        chk({txSkew, rxSkew}, 8'h00);
        $display("test registers done");
        ahb(1, `PMI_MAC_CTRL_OFF, 32'h3);
        for (int i = 0; i < 2; i++) begin
            ahb(1, `PMI_MAC_TXD_OFF, {23'h0, i[0], 8'ha5 ^ {8{i[0]}}});
            do @(negedge ref_clk); while (txStrobe !== 1'b1);
            chk(txByte, 8'ha5 ^ {8{i[0]}});
            chk({txErr, txFrame}, {i[0], 1'b1});
            do ahb(0, `PMI_MAC_STAT_OFF, 0); while (rd[0] !== 1'b0);
        end
        do @(negedge ref_clk); while (txFrame !== 1'b0);
        chk(link.txCtl, 1'b0);
        $display("test transmit done");
        for (int i = 0; i < 2; i++) begin
            @(posedge ref_clk) rxByte <= 8'h3c + 8'(i);
            rxValid <= 1'b1;
            rxErrIn <= i[0];
            do @(negedge ref_clk); while (rxTake !== 1'b1);
            @(posedge ref_clk) rxValid <= 1'b0;
            do ahb(0, `PMI_MAC_STAT_OFF, 0); while (rd[2:1] == 2'h0);
            chk(rd[15:8], 8'h3c + 8'(i));
            chk(rd[2], i[0]);
        end
        repeat (12) @(negedge ref_clk);
        chk(link.rxCtl, 1'b0);
        $display("test receive done");
        give_verdict();
    end
endmodule // rgmii_mac_side_interface_test
